/* src/drs_regs.svh */
// constants for the drive run supervisor: times, codes, field positions
// assumes a 100 MHz clock; included by bare name wherever needed
`ifndef DRS_REGS_SVH
`define DRS_REGS_SVH
// Overview of operation
// - emergency-stop input ramps output to zero on its own time and raises indication
// - emergency stop stays latched until run command and stop input are both gone
// - jog forward input (6) and jog reverse input (7) run while held
// - with start guard assigned, a run present at power-up never starts the motor
// - each analog output picks one quantity by 5-bit code; reserved codes give zero
// - analog output gain 0.0 to 1000.0 percent maps full scale to 10 V
// - analog output bias -100.0 to 100.0 percent maps zero to 0 V
// - regulator error is setpoint minus feedback
// - proportional path multiplies error by proportional gain
// - regulator runs only with mode bit 0 set, bypassed otherwise
// - mode bit 1 selects positive or inverted characteristic
// - mode 0001b speeds up, 0011b slows down, when feedback below setpoint
// - mode bit 2 takes derivative from error or from feedback
// - mode bit 3 adds target value to regulator output
// - feedback selector 1 takes first analog input, 2 the second
// - sleep when regulator output stays below sleep level for sleep delay
// - wake when regulator output stays above wake level for wake delay
// - sleep mode 0 off, 1 level and delay, 2 digital input command
// - ramp times span zero to maximum frequency, either direction

// ***********************************************
// scaling and timing
// ***********************************************
`define DRS_FMAX       16'h1770
`define DRS_FULL       12'hfff
`define DRS_CLK_NS     32'ha
`define DRS_TICK_NS    32'h186a0
`define DRS_TICK_CYC   ((`DRS_TICK_NS + `DRS_CLK_NS - 32'h1) / `DRS_CLK_NS)
`define DRS_UNIT_TICKS 10'h3e8
`define DRS_KP_DIV     32'sh64
`define DRS_AO_DIV     32'sh3e8
`define DRS_I_SHIFT    10
`define DRS_I_LIM      32'sh0177_0000

// ***********************************************
// input functions, modes, selectors
// ***********************************************
`define DRS_FN_JOG_FWD 6'h06
`define DRS_FN_JOG_REV 6'h07
`define DRS_FN_ESTOP   6'h0e
`define DRS_FN_GUARD   6'h32
`define DRS_FN_SLEEP   6'h33
`define DRS_M_EN       0
`define DRS_M_NEG      1
`define DRS_M_DFB      2
`define DRS_M_ADD      3
`define DRS_FB_AI2     2'h2
`define DRS_SLP_LVL    2'h1
`define DRS_SLP_DI     2'h2
`define DRS_AO_FREQ    5'h00
`define DRS_AO_CMD     5'h01
`define DRS_AO_VOLT    5'h02
`define DRS_AO_DCV     5'h03
`define DRS_AO_CURR    5'h04
`define DRS_AO_PWR     5'h05
`define DRS_AO_AI1     5'h08
`define DRS_AO_AI2     5'h09
`define DRS_AO_PIN     5'h15
`define DRS_AO_POUT    5'h16
`define DRS_AO_TGT     5'h17
`define DRS_AO_FB      5'h18
`endif

/* src/drs_pkg.sv */
// types shared by the drive run supervisor modules
// assumes drs_regs.svh for all numeric constants
package drs_pkg;
  typedef enum logic [1:0] {DRS_IDLE, DRS_RUN, DRS_HALT, DRS_SLEEP} drs_st_t;

  typedef struct packed {
    logic [7:0][5:0]     di_func;
    logic [15:0]         acc_t;
    logic [15:0]         dec_t;
    logic [15:0]         estop_t;
    logic [15:0]         jog_f;
    logic [3:0]          pid_mode;
    logic [1:0]          fb_sel;
    logic [15:0]         kp;
    logic [15:0]         ki;
    logic [15:0]         kd;
    logic [1:0]          sleep_mode;
    logic [15:0]         sleep_lvl;
    logic [15:0]         sleep_dly;
    logic [15:0]         wake_lvl;
    logic [15:0]         wake_dly;
    logic [4:0]          ao1_sel;
    logic [4:0]          ao2_sel;
    logic [13:0]         ao1_gain;
    logic [13:0]         ao2_gain;
    logic signed [10:0]  ao1_bias;
    logic signed [10:0]  ao2_bias;
  } drs_cfg_t;

  typedef struct packed {
    logic [11:0] volt;
    logic [11:0] dcv;
    logic [11:0] curr;
    logic [11:0] pwr;
  } drs_meas_t;

  typedef struct packed {
    logic [26:0] acc;
    logic [15:0] freq;
  } drs_ramp_st_t;

  typedef struct packed {
    logic [9:0]          s1;
    logic [9:0]          s2;
    logic [13:0]         pre;
    logic                tick;
    logic [9:0]          slow;
    logic                slow_tick;
    drs_st_t             st;
    logic                halt;
    logic                guard;
    logic                rev;
    logic signed [31:0]  integ;
    logic signed [16:0]  dprev;
    logic [15:0]         pid;
    logic [15:0]         slp_cnt;
  } drs_top_st_t;
endpackage

/* src/drs_ramp.sv */
// output frequency ramp generator
// assumes tick every 100 us from the same clock; times in 0.1 s units
`timescale 1ns/1ns
`include "drs_regs.svh"
module drs_ramp (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         tick,
  input  wire logic [15:0]  target,
  input  wire logic [15:0]  acc_t,
  input  wire logic [15:0]  dec_t,
  output logic      [15:0]  freq
);
  drs_pkg::drs_ramp_st_t q, d;
  logic [26:0] den;

  // ***********************************************
  // one unit step per clock at most, unless the ramp time is zero: then straight to target
  // ***********************************************
  always_comb
  begin
    d   = q;
    den = 27'(q.freq < target ? acc_t : dec_t) * 27'(`DRS_UNIT_TICKS);
    if (tick)
      d.acc = q.acc + 27'(`DRS_FMAX); // full span per ramp time
    if (q.freq == target)
      d.acc = '0;
    else if (den == '0)
    begin
      d.freq = target;
      d.acc  = '0;
    end
    else if (d.acc >= den)
    begin
      d.acc  = d.acc - den;
      d.freq = q.freq < target ? q.freq + 16'h1 : q.freq - 16'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      q <= '0;
    else
      q <= d;

  assign freq = q.freq;

  chk_ramp_step: assert property (@(posedge clk) disable iff (!arst_n)
    (acc_t != 16'h0 && dec_t != 16'h0) |=> (q.freq - $past(q.freq)) inside {16'h0, 16'h1, 16'hffff})
    else $error("ramp jumped more than one step");
endmodule // drs_ramp

/* src/drs_aout.sv */
// analog output scaler: gain and bias onto a 12-bit dac code
// assumes the selected quantity is already normalised to 12 bits
`timescale 1ns/1ns
`include "drs_regs.svh"
module drs_aout (
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire logic [11:0]        val,
  input  wire logic [13:0]        gain,
  input  wire logic signed [10:0] bias,
  output logic      [11:0]        dac
);
  logic [11:0] q, d;
  logic signed [31:0] g, b, s;

  always_comb
  begin
    g = (32'(val) * 32'(gain)) / `DRS_AO_DIV;
    b = (32'(bias) * $signed(32'(`DRS_FULL))) / `DRS_AO_DIV;
    s = g + b;
    // clamp rather than wrap: an overdriven channel pins at the rail
    if (s < 32'sh0)
      d = '0;
    else if (s > $signed(32'(`DRS_FULL)))
      d = `DRS_FULL;
    else
      d = s[11:0];
  end

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      q <= '0;
    else
      q <= d;

  assign dac = q;

  chk_aout_gain: assert property (@(posedge clk) disable iff (!arst_n)
    (bias == 11'sh0 && gain == 14'h3e8) |=> dac == $past(val))
    else $error("unit gain does not pass value through");
  chk_aout_bias: assert property (@(posedge clk) disable iff (!arst_n)
    (val == 12'h0 && bias <= 11'sh0) |=> dac == 12'h0)
    else $error("zero input with no positive bias not at 0 V");
endmodule // drs_aout

/* src/drs_top.sv */
// drive run supervisor: stop, jog, start guard, regulator, sleep, analog outs
// assumes terminals and run pins are asynchronous; analog codes and
// configuration come from logic on this clock
`timescale 1ns/1ns
`include "drs_regs.svh"
module drs_top #(
  parameter logic [13:0] TICK_CYC = 14'(`DRS_TICK_CYC)
) (
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic [7:0]           terminal_in,
  input  wire logic                 run_fwd_in,
  input  wire logic                 run_rev_in,
  input  wire drs_pkg::drs_cfg_t    cfg,
  input  wire drs_pkg::drs_meas_t   meas,
  input  wire logic [15:0]          freq_cmd,
  input  wire logic [11:0]          setpoint,
  input  wire logic [11:0]          analog_in_first,
  input  wire logic [11:0]          analog_in_second,
  output logic      [15:0]          freq_out,
  output logic                      dir_rev,
  output drs_pkg::drs_st_t          drive_state,
  output logic                      emergency_halt_indication,
  output logic                      unattended_start_guard,
  output logic      [15:0]          pid_out,
  output logic      [11:0]          analog_out_first,
  output logic      [11:0]          analog_out_second
);
  drs_pkg::drs_top_st_t q, d;

  logic [7:0]          pins;
  logic                rf, rr, jf, jr, run, estop, guard_on, sleep_di, sync_ok;
  logic [11:0]         fb;
  logic signed [16:0]  err, dsrc;
  logic signed [31:0]  pterm, dterm, sum;
  logic [15:0]         ref_f, target, dec_sel;
  logic [11:0]         ao1_val, ao2_val;

  // ***********************************************
  // helpers
  // ***********************************************
  function automatic logic di_hit(input logic [7:0][5:0] fn, input logic [7:0] m, input logic [5:0] code);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 8; i++)
      r = r | (m[i] & (fn[i] == code));
    return r;
  endfunction

  function automatic logic [11:0] f2c(input logic [15:0] f);
    return 12'((32'(f) * 32'(`DRS_FULL)) / 32'(`DRS_FMAX));
  endfunction

  // reserved and unsupported codes read as zero
  function automatic logic [11:0] ao_pick(input logic [4:0] sel, input drs_pkg::drs_meas_t m,
                                          input logic [15:0] fo, input logic [15:0] fc,
                                          input logic [15:0] pid, input logic signed [16:0] e,
                                          input logic [11:0] sp, input logic [11:0] fbv,
                                          input logic [11:0] a1, input logic [11:0] a2);
    logic [11:0] r;
    r = '0;
    case (sel)
      `DRS_AO_FREQ: r = f2c(fo);
      `DRS_AO_CMD:  r = f2c(fc);
      `DRS_AO_VOLT: r = m.volt;
      `DRS_AO_DCV:  r = m.dcv;
      `DRS_AO_CURR: r = m.curr;
      `DRS_AO_PWR:  r = m.pwr;
      `DRS_AO_AI1:  r = a1;
      `DRS_AO_AI2:  r = a2;
      `DRS_AO_PIN:  r = e[16] ? 12'h0 : e[11:0];
      `DRS_AO_POUT: r = f2c(pid);
      `DRS_AO_TGT:  r = sp;
      `DRS_AO_FB:   r = fbv;
      default:      r = '0;
    endcase
    return r;
  endfunction

  // ***********************************************
  // decoded inputs
  // ***********************************************
  assign pins     = q.s2[7:0];
  assign rf       = q.s2[8];
  assign rr       = q.s2[9];
  assign jf       = di_hit(cfg.di_func, pins, `DRS_FN_JOG_FWD);
  assign jr       = di_hit(cfg.di_func, pins, `DRS_FN_JOG_REV);
  assign estop    = di_hit(cfg.di_func, pins, `DRS_FN_ESTOP);
  assign guard_on = di_hit(cfg.di_func, 8'hff, `DRS_FN_GUARD);
  assign sleep_di = di_hit(cfg.di_func, pins, `DRS_FN_SLEEP);
  assign run      = rf | rr | jf | jr;
  // the synchroniser shows reset zeros for two edges: a run held at power-up
  // must not read as withdrawn before the real pin levels arrive
  assign sync_ok  = (q.pre > 14'h1) || q.tick || q.slow_tick || (q.slow != 10'h0);

  // ***********************************************
  // regulator arithmetic
  // ***********************************************
  assign fb    = (cfg.fb_sel == `DRS_FB_AI2) ? analog_in_second : analog_in_first;
  assign err   = $signed({5'h0, setpoint}) - $signed({5'h0, fb});
  assign dsrc  = cfg.pid_mode[`DRS_M_DFB] ? -$signed({5'h0, fb}) : err;
  assign pterm = ($signed({16'h0, cfg.kp}) * 32'(err)) / `DRS_KP_DIV;
  assign dterm = ($signed({16'h0, cfg.kd}) * 32'(dsrc - q.dprev)) / `DRS_KP_DIV;

  always_comb
  begin
    sum = pterm + (q.integ >>> `DRS_I_SHIFT) + dterm;
    if (cfg.pid_mode[`DRS_M_NEG])
      sum = -sum;
    if (cfg.pid_mode[`DRS_M_ADD])
      sum = sum + 32'(f2c(16'h0) + 12'h0) + 32'((32'(setpoint) * 32'(`DRS_FMAX)) / 32'(`DRS_FULL));
  end

  assign ref_f   = cfg.pid_mode[`DRS_M_EN] ? q.pid : freq_cmd;
  assign target  = (q.st != drs_pkg::DRS_RUN) ? 16'h0 :
                   ((jf | jr) & ~(rf | rr)) ? cfg.jog_f : ref_f;
  assign dec_sel = q.halt ? cfg.estop_t : cfg.dec_t;

  // ***********************************************
  // next state
  // ***********************************************
  always_comb
  begin
    d           = q;
    d.s1        = {run_rev_in, run_fwd_in, terminal_in};
    d.s2        = q.s1;
    d.tick      = 1'b0;
    d.slow_tick = 1'b0;
    if (q.pre == TICK_CYC - 14'h1)
    begin
      d.pre  = '0;
      d.tick = 1'b1;
    end
    else
      d.pre = q.pre + 14'h1;
    if (q.tick)
    begin
      if (q.slow == `DRS_UNIT_TICKS - 10'h1)
      begin
        d.slow      = '0;
        d.slow_tick = 1'b1;
      end
      else
        d.slow = q.slow + 10'h1;
    end

    // regulator update once per tick; cleared while bypassed
    if (!cfg.pid_mode[`DRS_M_EN])
    begin
      d.integ = '0;
      d.dprev = '0;
      d.pid   = '0;
    end
    else if (q.tick)
    begin
      d.integ = q.integ + $signed({16'h0, cfg.ki}) * 32'(err);
      // windup limit keeps a saturated loop from lingering on recovery
      if (d.integ > `DRS_I_LIM)
        d.integ = `DRS_I_LIM;
      else if (d.integ < -`DRS_I_LIM)
        d.integ = -`DRS_I_LIM;
      d.dprev = dsrc;
      if (sum < 32'sh0)
        d.pid = '0;
      else if (sum > 32'(`DRS_FMAX))
        d.pid = `DRS_FMAX;
      else
        d.pid = sum[15:0];
    end

    // start guard armed at reset, dropped once run is seen idle
    if (!guard_on || (!run && sync_ok))
      d.guard = 1'b0;

    // emergency stop latch
    if (estop)
      d.halt = 1'b1;
    else if (!run)
      d.halt = 1'b0;

    if (q.st == drs_pkg::DRS_RUN)
      d.rev = rr | (jr & ~rf);

    case (q.st)
      drs_pkg::DRS_IDLE:
      begin
        d.slp_cnt = '0;
        if (run && !q.guard && !q.halt)
          d.st = drs_pkg::DRS_RUN;
      end
      drs_pkg::DRS_RUN:
      begin
        if (!run)
          d.st = drs_pkg::DRS_IDLE;
        else if (cfg.sleep_mode == `DRS_SLP_DI)
        begin
          if (sleep_di)
            d.st = drs_pkg::DRS_SLEEP;
        end
        else if (cfg.sleep_mode == `DRS_SLP_LVL && q.pid < cfg.sleep_lvl)
        begin
          if (q.slp_cnt >= cfg.sleep_dly)
          begin
            d.st      = drs_pkg::DRS_SLEEP;
            d.slp_cnt = '0;
          end
          else if (q.slow_tick)
            d.slp_cnt = q.slp_cnt + 16'h1;
        end
        else
          d.slp_cnt = '0;
      end
      drs_pkg::DRS_SLEEP:
      begin
        if (!run)
          d.st = drs_pkg::DRS_IDLE;
        else if (cfg.sleep_mode == `DRS_SLP_DI)
        begin
          if (!sleep_di)
            d.st = drs_pkg::DRS_RUN;
        end
        else if (cfg.sleep_mode != `DRS_SLP_LVL)
          d.st = drs_pkg::DRS_RUN;
        else if (q.pid > cfg.wake_lvl)
        begin
          if (q.slp_cnt >= cfg.wake_dly)
          begin
            d.st      = drs_pkg::DRS_RUN;
            d.slp_cnt = '0;
          end
          else if (q.slow_tick)
            d.slp_cnt = q.slp_cnt + 16'h1;
        end
        else
          d.slp_cnt = '0;
      end
      drs_pkg::DRS_HALT:
      begin
        d.slp_cnt = '0;
        if (!q.halt)
          d.st = drs_pkg::DRS_IDLE;
      end
      default:
        d.st = drs_pkg::DRS_IDLE;
    endcase
    if (q.halt)
      d.st = drs_pkg::DRS_HALT;
  end

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      q       <= '0;
      q.guard <= 1'b1;
    end
    else
      q <= d;

  // ***********************************************
  // submodules
  // ***********************************************
  drs_ramp u_ramp (
    .clk    (clk),
    .arst_n (arst_n),
    .tick   (q.tick),
    .target (target),
    .acc_t  (cfg.acc_t),
    .dec_t  (dec_sel),
    .freq   (freq_out)
  );

  assign ao1_val = ao_pick(cfg.ao1_sel, meas, freq_out, freq_cmd, q.pid, err, setpoint, fb,
                           analog_in_first, analog_in_second);
  assign ao2_val = ao_pick(cfg.ao2_sel, meas, freq_out, freq_cmd, q.pid, err, setpoint, fb,
                           analog_in_first, analog_in_second);

  drs_aout u_ao1 (
    .clk    (clk),
    .arst_n (arst_n),
    .val    (ao1_val),
    .gain   (cfg.ao1_gain),
    .bias   (cfg.ao1_bias),
    .dac    (analog_out_first)
  );

  drs_aout u_ao2 (
    .clk    (clk),
    .arst_n (arst_n),
    .val    (ao2_val),
    .gain   (cfg.ao2_gain),
    .bias   (cfg.ao2_bias),
    .dac    (analog_out_second)
  );

  assign dir_rev                   = q.rev;
  assign drive_state               = q.st;
  assign emergency_halt_indication = q.halt;
  assign unattended_start_guard    = q.guard;
  assign pid_out                   = q.pid;

  // ***********************************************
  // checks
  // ***********************************************
  chk_halt_raise: assert property (@(posedge clk) disable iff (!arst_n)
    estop |=> q.halt ##1 (q.st == drs_pkg::DRS_HALT && target == 16'h0))
    else $error("stop input did not halt");
  chk_halt_latch: assert property (@(posedge clk) disable iff (!arst_n)
    (q.halt && run) |=> q.halt)
    else $error("halt dropped while run present");
  chk_guard_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (q.guard && q.st == drs_pkg::DRS_IDLE) |=> q.st != drs_pkg::DRS_RUN)
    else $error("guarded start ran");
  chk_jog_dir: assert property (@(posedge clk) disable iff (!arst_n)
    (q.st == drs_pkg::DRS_RUN && jr && !rf && !rr) |=> dir_rev)
    else $error("reverse jog not reverse");
  chk_pid_bypass: assert property (@(posedge clk) disable iff (!arst_n)
    !cfg.pid_mode[`DRS_M_EN] |=> (q.pid == 16'h0 && q.integ == 32'sh0))
    else $error("regulator active while disabled");
  chk_sleep_out: assert property (@(posedge clk) disable iff (!arst_n)
    q.st == drs_pkg::DRS_SLEEP |-> target == 16'h0)
    else $error("output not off in sleep");
  chk_sleep_off: assert property (@(posedge clk) disable iff (!arst_n)
    (cfg.sleep_mode == 2'h0 && q.st == drs_pkg::DRS_RUN) |=> q.st != drs_pkg::DRS_SLEEP)
    else $error("slept with sleep disabled");
  chk_err_sign: assert property (@(posedge clk) disable iff (!arst_n)
    (setpoint > fb) |-> !err[16])
    else $error("error sign wrong");
  chk_guard_sync: assert property (@(posedge clk) disable iff (!arst_n)
    (q.guard && guard_on && !sync_ok) |=> q.guard)
    else $error("guard dropped before pins were synchronised");
  chk_fb_first: assert property (@(posedge clk) disable iff (!arst_n)
    (cfg.fb_sel == 2'h1) |-> fb == analog_in_first)
    else $error("feedback not from first analog input");
  chk_fb_second: assert property (@(posedge clk) disable iff (!arst_n)
    (cfg.fb_sel == `DRS_FB_AI2) |-> fb == analog_in_second)
    else $error("feedback not from second analog input");
  chk_d_source: assert property (@(posedge clk) disable iff (!arst_n)
    (cfg.pid_mode[`DRS_M_EN] && cfg.pid_mode[`DRS_M_DFB] && q.tick) |=> q.dprev == -$signed({5'h0, $past(fb)}))
    else $error("derivative not taken from feedback");
  chk_sleep_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (q.st == drs_pkg::DRS_RUN && cfg.sleep_mode == `DRS_SLP_LVL && q.pid >= cfg.sleep_lvl) |=> q.st != drs_pkg::DRS_SLEEP)
    else $error("slept above sleep level");
  chk_wake_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (q.st == drs_pkg::DRS_SLEEP && cfg.sleep_mode == `DRS_SLP_LVL && q.pid <= cfg.wake_lvl) |=> q.st != drs_pkg::DRS_RUN)
    else $error("woke below wake level");
  chk_pid_pos: assert property (@(posedge clk) disable iff (!arst_n)
    (cfg.pid_mode == 4'h1 && q.tick && cfg.kd == 16'h0 && q.integ >= 32'sh0 && pterm > 32'sh0) |=> q.pid != 16'h0)
    else $error("forward mode did not raise speed");
  chk_pid_neg: assert property (@(posedge clk) disable iff (!arst_n)
    (cfg.pid_mode == 4'h3 && q.tick && cfg.kd == 16'h0 && q.integ >= 32'sh0 && err > 17'sh0) |=> q.pid == 16'h0)
    else $error("inverted mode did not lower speed");
endmodule // drs_top

/* dv/drs_stage_model.sv */
// power stage stand-in: turns output frequency and a load figure into measurements
// assumes the bench sets load; the dc bus sits at a fixed level
`timescale 1ns/1ns
module drs_stage_model (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic [15:0]   freq_out,
  input  wire logic [11:0]   load,
  output drs_pkg::drs_meas_t meas
);
  // ***********************************************
  // measurements, one clock behind the drive
  // ***********************************************
  // a real stage lags far more; one clock is enough to keep values stable while idle
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      meas <= '0;
    else
    begin
      meas.volt <= freq_out[12:1];
      meas.dcv  <= 12'hc00;
      meas.curr <= load;
      meas.pwr  <= {1'b0, load[11:1]};
    end
endmodule // drs_stage_model

/* dv/testbench.sv */
// self-checking bench for drs_top with random analog settings
// assumes drs_stage_model stands in for the power stage
`timescale 1ns/1ns
module testbench;
  logic               clk = 1'b0;
  logic               arst_n = 1'b0;
  logic [7:0]         term = '0;
  logic               run_f = 1'b1;
  logic               run_r = 1'b0;
  drs_pkg::drs_cfg_t  cfg = '0;
  drs_pkg::drs_meas_t meas;
  drs_pkg::drs_st_t   st;
  logic [15:0]        fcmd = 16'h03e8;
  logic [11:0]        sp = '0, ai1 = '0, ai2 = '0, load = '0, ao1, ao2;
  logic [15:0]        fo, po, p1;
  logic               dr, ind, grd;
  int                 num_errors = 0, compares = 0, cyc = 0, i;
  int                 seed = 32'hd1d6b054;

  drs_top #(.TICK_CYC(14'h00a)) dut_u (.clk(clk), .arst_n(arst_n), .terminal_in(term),
    .run_fwd_in(run_f), .run_rev_in(run_r), .cfg(cfg), .meas(meas), .freq_cmd(fcmd),
    .setpoint(sp), .analog_in_first(ai1), .analog_in_second(ai2), .freq_out(fo),
    .dir_rev(dr), .drive_state(st), .emergency_halt_indication(ind),
    .unattended_start_guard(grd), .pid_out(po), .analog_out_first(ao1), .analog_out_second(ao2));
  drs_stage_model stage_u (.clk(clk), .arst_n(arst_n), .freq_out(fo), .load(load), .meas(meas));

  initial
  begin
    forever #5 clk = ~clk;
  end

  // ***********************************************
  // checking helpers
  // ***********************************************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    if (num_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // bounded waits; the caller compares afterwards
  task automatic wst(input drs_pkg::drs_st_t s, input int n);
    for (int k = 0; k < n && st !== s; k++)
      @(negedge clk);
  endtask

  task automatic wfo(input logic [15:0] f, input int n);
    for (int k = 0; k < n && fo !== f; k++)
      @(negedge clk);
  endtask

  function automatic logic [11:0] qty(input int c);
    case (c)
      2: return meas.volt;
      3: return meas.dcv;
      4: return meas.curr;
      5: return meas.pwr;
      8: return ai1;
      9: return ai2;
      default: return 12'h000;
    endcase
  endfunction

  function automatic logic [11:0] ao_exp(input int v, input int g, input int b);
    int r;
    r = v * g / 1000 + b * 4095 / 1000;
    return (r < 0) ? 12'h000 : (r > 4095) ? 12'hfff : 12'(r);
  endfunction

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      num_errors++;
      results();
    end
  end

  // ***********************************************
  // main sequence
  // ***********************************************
  initial
  begin
    cfg.di_func[0] = 6'h32;
    cfg.di_func[1] = 6'h0e;
    cfg.di_func[2] = 6'h06;
    cfg.di_func[3] = 6'h07;
    cfg.di_func[4] = 6'h33;
    cfg.acc_t = 16'h0001;
    cfg.dec_t = 16'h0001;
    cfg.jog_f = 16'h012c;
    cfg.fb_sel = 2'h1;
    cfg.kp = 16'h00c8; // fan and pump tuning
    cfg.sleep_lvl = 16'h0064;
    cfg.sleep_dly = 16'h0001;
    cfg.wake_lvl = 16'h01f4;
    cfg.wake_dly = 16'h0001;
    repeat (16) @(negedge clk);
    chk("guard_rst", grd, 1'b1);
    arst_n = 1'b1;
    repeat (20) @(negedge clk);
    chk("state_guarded", st, drs_pkg::DRS_IDLE);
    run_f = 1'b0;
    repeat (10) @(negedge clk);
    chk("guard_off", grd, 1'b0);
    run_f = 1'b1;
    wst(drs_pkg::DRS_RUN, 10);
    chk("state_run", st, drs_pkg::DRS_RUN);
    // 1000 units at 6000 per 10000 cycles: about 1667 cycles
    repeat (1400) @(negedge clk);
    chk("ramp_slow", 32'(fo < 16'h03e8), 32'h1);
    wfo(16'h03e8, 800);
    chk("bypass_freq", fo, 16'h03e8);
    term[1] = 1'b1;
    wst(drs_pkg::DRS_HALT, 10);
    chk("halt_ind", ind, 1'b1);
    chk("halt_state", st, drs_pkg::DRS_HALT);
    wfo(16'h0000, 50);
    chk("halt_zero", fo, 16'h0000);
    term[1] = 1'b0;
    repeat (10) @(negedge clk);
    chk("halt_kept", ind, 1'b1);
    run_f = 1'b0;
    wst(drs_pkg::DRS_IDLE, 10);
    chk("halt_clear", ind, 1'b0);
    term[2] = 1'b1;
    wfo(16'h012c, 1000);
    chk("jog_fwd", {dr, fo}, {1'b0, 16'h012c});
    term[2] = 1'b0;
    term[3] = 1'b1;
    for (i = 0; i < 2000 && dr !== 1'b1; i++)
      @(negedge clk);
    chk("jog_rev", dr, 1'b1);
    term[3] = 1'b0;
    wfo(16'h0000, 1000);
    fcmd = 16'h0000;
    for (i = 0; i < 15; i++)
    begin
      cfg.ao1_sel = 5'(i);
      cfg.ao2_sel = 5'(14 - i);
      cfg.ao1_gain = 14'($unsigned($random(seed)) % 10001);
      cfg.ao2_gain = 14'($unsigned($random(seed)) % 10001);
      cfg.ao1_bias = 11'($random(seed) % 1001);
      cfg.ao2_bias = 11'($random(seed) % 1001);
      {load, ai1, ai2} = 36'($random(seed));
      repeat (4) @(negedge clk);
      chk("ao_first", ao1, ao_exp(qty(i), cfg.ao1_gain, cfg.ao1_bias));
      chk("ao_second", ao2, ao_exp(qty(14 - i), cfg.ao2_gain, cfg.ao2_bias));
    end
    cfg.ao1_sel = 5'h18;
    cfg.ao2_sel = 5'h17;
    sp = 12'h5a5;
    repeat (4) @(negedge clk);
    chk("ao_feedback", ao1, ao_exp(ai1, cfg.ao1_gain, cfg.ao1_bias));
    chk("ao_target", ao2, ao_exp(sp, cfg.ao2_gain, cfg.ao2_bias));
    run_f = 1'b1;
    cfg.pid_mode = 4'h1; // regulator chosen as the frequency reference
    {sp, ai1, ai2} = {12'hfff, 12'hfff, 12'h000};
    repeat (40) @(negedge clk);
    chk("pid_zero_err", po, 16'h0000);
    cfg.fb_sel = 2'h2;
    repeat (40) @(negedge clk);
    chk("pid_fb_second", po, 16'h1770);
    cfg.pid_mode = 4'h3;
    repeat (40) @(negedge clk);
    chk("pid_inverted", po, 16'h0000);
    cfg.pid_mode = 4'h9;
    cfg.fb_sel = 2'h1;
    repeat (40) @(negedge clk);
    chk("pid_add_tgt", po, 16'h1770);
    cfg.pid_mode = 4'h1;
    {sp, ai1, cfg.kp} = {12'h800, 12'h7c0, 16'h0064};
    repeat (40) @(negedge clk);
    p1 = po;
    cfg.kp = 16'h00c8;
    repeat (40) @(negedge clk);
    chk("pid_double", 32'(p1 != 0 && po >= 2 * p1 - 1 && po <= 2 * p1 + 1), 32'h1);
    {sp, ai1, cfg.sleep_mode} = {12'h800, 12'h800, 2'h1};
    wst(drs_pkg::DRS_SLEEP, 25000);
    chk("sleep_lvl", st, drs_pkg::DRS_SLEEP);
    ai1 = 12'h000;
    wst(drs_pkg::DRS_RUN, 25000);
    chk("wake", st, drs_pkg::DRS_RUN);
    cfg.sleep_mode = 2'h2;
    term[4] = 1'b1;
    wst(drs_pkg::DRS_SLEEP, 20);
    chk("sleep_input", st, drs_pkg::DRS_SLEEP);
    results();
  end
endmodule // testbench
